// [verilog/mcg_defines.vh]
// Constants for the clock generation block
`ifndef MCG_DEFINES_VH
`define MCG_DEFINES_VH
// ==========================================
// Register addresses
`define MCG_CLKCTL_ADDR    16'hffde
`define MCG_TRIM_ADDR      8'h96
`define MCG_DIVIDER_ADDR   8'h95
`define MCG_AUXCTL_ADDR    8'ha2
// ==========================================
// Clock source control fields
`define MCG_CC_OK_BIT      7
`define MCG_CC_WDRATE_BIT  5
`define MCG_CC_XTALWD_BIT  4
`define MCG_CC_DBL_BIT     3
`define MCG_CC_WMASK       8'h3f
// Config byte fields; byte one loaded on reset, byte two read continuously
`define MCG_UC1_DBL_BIT    7
`define MCG_UC2_DBL_BIT    7
// Trim register fields
`define MCG_TRIM_CLOCK_OUTPUT_ENABLE_BIT 6
`define MCG_TRIM_RCSEL_BIT 7
// Auxiliary control field
`define MCG_AUX_LP_BIT     7
`define MCG_AUX_RESET      8'h00
// ==========================================
// Source select codes
`define MCG_SRC_XTAL_HI    3'h0
`define MCG_SRC_XTAL_MED   3'h1
`define MCG_SRC_XTAL_LO    3'h2
`define MCG_SRC_RC         3'h3
`define MCG_SRC_WDOSC      3'h4
`define MCG_SRC_EXT        3'h7
// ==========================================
// Timing: new source edges counted before a switch takes effect
`define MCG_SWITCH_TICKS   6'd32
`define MCG_DIVIDER_RESET  8'h00
`endif

// [verilog/mcg_core_divider.v]
// Programmable divider from oscillator-select ticks to core clock ticks
`timescale 1ns/10ps
`include "mcg_defines.vh"
module mcg_core_divider #(
  parameter W = 8
) (
  input  wire         clk_in,     // System clock
  input  wire         srst_in,    // Sync reset
  input  wire         tick_in,    // Oscillator-select tick
  input  wire [W-1:0] div_in,     // Divide value, factor is 2*div, 0 means 1
  output reg          tick_out    // Core clock tick
);
  reg [W:0] cnt_r;
  wire [W:0] lim = (div_in == {W{1'b0}}) ? {(W+1){1'b0}} : ({div_in, 1'b0} - {{W{1'b0}}, 1'b1});

  // ==========================================
  // Divider; new value applies at once to the count in progress, no halt needed
  always @(posedge clk_in) begin
    if (srst_in) begin
      cnt_r    <= {(W+1){1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_r >= lim) begin
          cnt_r    <= {(W+1){1'b0}};
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + {{W{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // mcg_core_divider

// [verilog/mcg_clock_gen.v]
// Clock generation: source select, divider, core, peripheral and output clocks
//
// Contract
// - A machine cycle is two core clock cycles.
// - Peripheral clock runs at half the core clock.
// - Oscillator-select clock picks one of four sources and feeds the divider.
// - Source choice defaults from nonvolatile configuration bytes.
// - Doubler bit set makes the RC clock run twice nominal rate.
// - Crystal feeds select clock and RTC; only low-speed crystal may feed watchdog.
// - Watchdog oscillator has two selectable rates and can clock the system.
// - Clock output only when crystal is unused by system, RTC and watchdog.
// - Clock output driven only while the output enable trim bit is set.
// - Clock output toggles once per core clock tick.
// - Six-bit RC tune field loads factory value on reset; software may rewrite.
// - Low-power select bit clears on reset; set only at slow core clock (not checked here: an auxiliary register write sets it at any clock).
// - Source bits and doubler load from config byte one on reset.
// - Clock source control is an extended register in external data space.
// - Switch-complete flag clears at switch start, sets at finish.
// - Divider up to 510, changeable at any time.
`timescale 1ns/10ps
`include "mcg_defines.vh"
module mcg_clock_gen #(
  parameter DIV_W = 8
) (
  input  wire        clk_in,         // 200 MHz system clock
  input  wire        srst_in,        // Sync reset, active high
  input  wire [7:0]  user_config_byte_one_in,       // User config byte one
  input  wire [7:0]  user_config_byte_two_in,       // User config byte two
  input  wire [5:0]  trim_factory_in,// Factory RC tune value
  input  wire        xtal_osc_in,    // Crystal oscillator pin level
  input  wire        rc_osc_in,      // Internal RC oscillator level
  input  wire        wd_osc_in,      // Watchdog oscillator level
  input  wire        ext_clk_in,     // External clock pin level
  input  wire        rtc_xtal_in,    // RTC is using the crystal
  input  wire [15:0] xaddr_in,       // External data address
  input  wire [7:0]  xwdata_in,      // External data write data
  input  wire        xwr_in,         // External data write strobe
  input  wire        xrd_in,         // External data read strobe
  input  wire [7:0]  sfr_addr_in,    // Direct register address
  input  wire [7:0]  sfr_wdata_in,   // Direct register write data
  input  wire        sfr_wr_in,      // Direct register write strobe
  input  wire        sfr_rd_in,      // Direct register read strobe
  output reg  [7:0]  xrdata_out,     // External data read data
  output reg  [7:0]  sfr_rdata_out,  // Direct register read data
  output reg         osc_tick_out,   // Oscillator-select clock tick
  output reg         cpu_tick_out,   // Core clock tick
  output reg         cpu_clk_out,    // Core clock phase level
  output reg         periph_tick_out,// Peripheral clock tick
  output reg         mcycle_end_out, // Last core cycle of machine cycle
  output reg         rc_dbl_out,     // RC doubler enable to oscillator
  output reg  [5:0]  rc_trim_out,    // RC tune to oscillator
  output reg         wd_rate_out,    // Watchdog oscillator rate select
  output reg         wdt_xtal_out,   // Watchdog clocked from crystal
  output reg         low_power_out,  // Low-power clock select
  output reg         clock_output_pin_o_out,   // Clock output pin data
  output reg         clock_output_pin_oe_n_out // Clock output pin enable, low drives
);
  // ==========================================
  // Pin synchronisers and edge detect
  reg [3:0] s1_r, s2_r, s3_r;
  wire [3:0] raw = {ext_clk_in, wd_osc_in, rc_osc_in, xtal_osc_in};
  wire [3:0] rise = s2_r & ~s3_r;
  wire [3:0] edge_any = s2_r ^ s3_r;
  always @(posedge clk_in) begin
    if (srst_in) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================
  // Registers
  reg [2:0]       src_r;        // Control register source field
  reg [2:0]       act_r;        // Source now feeding the divider
  reg             dbl_r;
  reg             xtalwd_r;
  reg             wdrate_r;
  reg             ok_r;
  reg [5:0]       sw_cnt_r;
  reg [5:0]       trim_r;
  reg             clock_output_enable_r;
  reg             rcsel_r;
  reg             lp_r;
  reg [DIV_W-1:0] div_r;
  reg             phase_r;
  reg             clock_output_pin_en_r;

  wire dbl_on = dbl_r | user_config_byte_two_in[`MCG_UC2_DBL_BIT];

  // Source tick for a select code
  function src_tick;
    input [2:0] code;
    begin
      case (code)
        `MCG_SRC_XTAL_HI,
        `MCG_SRC_XTAL_MED,
        `MCG_SRC_XTAL_LO: src_tick = rise[0];
        `MCG_SRC_RC:      src_tick = dbl_on ? edge_any[1] : rise[1];
        `MCG_SRC_WDOSC:   src_tick = rise[2];
        `MCG_SRC_EXT:     src_tick = rise[3];
        default:          src_tick = dbl_on ? edge_any[1] : rise[1];
      endcase
    end
  endfunction

  function is_xtal;
    input [2:0] code;
    begin
      is_xtal = (code == `MCG_SRC_XTAL_HI) || (code == `MCG_SRC_XTAL_MED) || (code == `MCG_SRC_XTAL_LO);
    end
  endfunction

  wire act_tick = src_tick(act_r);
  wire new_tick = src_tick(src_r);
  wire cc_wr = xwr_in && (xaddr_in == `MCG_CLKCTL_ADDR);
  wire [7:0] cc_rd = {ok_r, 1'b0, wdrate_r, xtalwd_r, dbl_r, src_r};

  // ==========================================
  // Clock source control and switching
  always @(posedge clk_in) begin
    if (srst_in) begin
      src_r    <= user_config_byte_one_in[2:0];
      act_r    <= user_config_byte_one_in[2:0];
      dbl_r    <= user_config_byte_one_in[`MCG_UC1_DBL_BIT];
      xtalwd_r <= 1'b0;
      wdrate_r <= 1'b0;
      ok_r     <= 1'b1;
      sw_cnt_r <= 6'h00;
    end else if (!ok_r) begin
      // Old source keeps running until the new one is proven alive
      if (new_tick && (sw_cnt_r != `MCG_SWITCH_TICKS))
        sw_cnt_r <= sw_cnt_r + 6'h01;
      if ((sw_cnt_r == `MCG_SWITCH_TICKS) && !act_tick) begin
        act_r <= src_r;
        ok_r  <= 1'b1;
      end
    end else if (cc_wr) begin
      dbl_r    <= xwdata_in[`MCG_CC_DBL_BIT];
      wdrate_r <= xwdata_in[`MCG_CC_WDRATE_BIT];
      // Only the low-speed crystal may clock the watchdog
      xtalwd_r <= xwdata_in[`MCG_CC_XTALWD_BIT] &&
                  (xwdata_in[2:0] == `MCG_SRC_XTAL_LO);
      src_r    <= xwdata_in[2:0];
      if (xwdata_in[2:0] != act_r) begin
        ok_r     <= 1'b0;
        sw_cnt_r <= 6'h00;
      end
    end
  end

  // ==========================================
  // Direct registers: trim, divider, auxiliary
  always @(posedge clk_in) begin
    if (srst_in) begin
      trim_r  <= trim_factory_in;
      clock_output_enable_r <= 1'b0;
      rcsel_r <= 1'b0;
      lp_r    <= 1'b0;
      div_r   <= `MCG_DIVIDER_RESET;
    end else if (sfr_wr_in) begin
      case (sfr_addr_in)
        `MCG_TRIM_ADDR: begin
          trim_r  <= sfr_wdata_in[5:0];
          clock_output_enable_r <= sfr_wdata_in[`MCG_TRIM_CLOCK_OUTPUT_ENABLE_BIT];
          rcsel_r <= sfr_wdata_in[`MCG_TRIM_RCSEL_BIT];
        end
        `MCG_DIVIDER_ADDR: div_r <= sfr_wdata_in[DIV_W-1:0];
        `MCG_AUXCTL_ADDR:  lp_r  <= sfr_wdata_in[`MCG_AUX_LP_BIT];
        default: ;
      endcase
    end
  end

  // ==========================================
  // Divider
  wire div_tick;
  mcg_core_divider #(
    .W        (DIV_W)
  ) u_div (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .tick_in  (act_tick),
    .div_in   (div_r),
    .tick_out (div_tick)
  );

  // ==========================================
  // Outputs, all registered
  always @(posedge clk_in) begin
    if (srst_in) begin
      xrdata_out      <= 8'h00;
      sfr_rdata_out   <= 8'h00;
      osc_tick_out    <= 1'b0;
      cpu_tick_out    <= 1'b0;
      cpu_clk_out     <= 1'b0;
      periph_tick_out <= 1'b0;
      mcycle_end_out  <= 1'b0;
      phase_r         <= 1'b0;
      clock_output_pin_en_r     <= 1'b0;
      rc_dbl_out      <= 1'b0;
      rc_trim_out     <= 6'h00;
      wd_rate_out     <= 1'b0;
      wdt_xtal_out    <= 1'b0;
      low_power_out   <= 1'b0;
      clock_output_pin_o_out    <= 1'b0;
      clock_output_pin_oe_n_out <= 1'b1;
    end else begin
      xrdata_out <= (xrd_in && (xaddr_in == `MCG_CLKCTL_ADDR)) ? cc_rd : 8'h00;
      case (sfr_addr_in)
        `MCG_TRIM_ADDR:    sfr_rdata_out <= sfr_rd_in ? {rcsel_r, clock_output_enable_r, trim_r} : 8'h00;
        `MCG_DIVIDER_ADDR: sfr_rdata_out <= sfr_rd_in ? {{(8-DIV_W){1'b0}}, div_r} : 8'h00;
        `MCG_AUXCTL_ADDR:  sfr_rdata_out <= sfr_rd_in ? {lp_r, 7'h00} : 8'h00;
        default:           sfr_rdata_out <= 8'h00;
      endcase
      osc_tick_out <= act_tick;
      cpu_tick_out <= div_tick;
      if (div_tick) begin
        phase_r     <= ~phase_r;
        cpu_clk_out <= ~cpu_clk_out;
      end
      periph_tick_out <= div_tick && phase_r;
      mcycle_end_out  <= div_tick && phase_r;
      rc_dbl_out      <= dbl_on;
      rc_trim_out     <= trim_r;
      wd_rate_out     <= wdrate_r;
      wdt_xtal_out    <= xtalwd_r;
      low_power_out   <= lp_r;
      // Pin is shared with the crystal, so only free when nothing uses it
      clock_output_pin_en_r <= clock_output_enable_r && !is_xtal(act_r) && !is_xtal(src_r) &&
                     !xtalwd_r && !rtc_xtal_in;
      clock_output_pin_oe_n_out <= ~clock_output_pin_en_r;
      if (!clock_output_pin_en_r)
        clock_output_pin_o_out <= 1'b0;
      else if (div_tick)
        clock_output_pin_o_out <= ~clock_output_pin_o_out;
    end
  end
endmodule // mcg_clock_gen

// [testbench/mcg_clock_gen_checker.sv]
// Concurrent checks on the clock generation block ports
`timescale 1ns/10ps
`include "mcg_defines.vh"
module mcg_clock_gen_checker (
  input wire        clk_in,          // Clock
  input wire        srst_in,         // Reset
  input wire [7:0]  user_config_byte_two_in,        // Config two
  input wire [15:0] xaddr_in,        // Ext address
  input wire        xrd_in,          // Ext read
  input wire [7:0]  sfr_addr_in,     // Direct address
  input wire        sfr_rd_in,       // Direct read
  input wire [7:0]  xrdata_out,      // Ext data
  input wire [7:0]  sfr_rdata_out,   // Direct data
  input wire        osc_tick_out,    // Select tick
  input wire        cpu_tick_out,    // Core tick
  input wire        cpu_clk_out,     // Core level
  input wire        periph_tick_out, // Periph tick
  input wire        mcycle_end_out,  // Machine cycle end
  input wire        rc_dbl_out,      // Doubler
  input wire        low_power_out,   // Low power
  input wire        clock_output_pin_o_out,    // Pin data
  input wire        clock_output_pin_oe_n_out  // Pin enable
);
  reg ph_r;
  always @(posedge clk_in)
    if (srst_in) ph_r <= 1'b0;
    else if (cpu_tick_out) ph_r <= ~ph_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_dbl_held; user_config_byte_two_in[7] [*3]; endsequence
  sequence s_pin_idle; clock_output_pin_oe_n_out [*4]; endsequence
  reset_idle_a: assert property (
    $past(srst_in) |-> clock_output_pin_oe_n_out && !low_power_out && !cpu_tick_out) else $error("outputs busy after reset");
  xdata_quiet_a: assert property (
    !(xrd_in && xaddr_in == `MCG_CLKCTL_ADDR) |=> xrdata_out == 8'h00) else $error("stray ext read data");
  sfr_quiet_a: assert property (
    !(sfr_rd_in && (sfr_addr_in == `MCG_TRIM_ADDR || sfr_addr_in == `MCG_DIVIDER_ADDR ||
    sfr_addr_in == `MCG_AUXCTL_ADDR)) |=> sfr_rdata_out == 8'h00) else $error("stray direct read data");
  machine_cycle_a: assert property (mcycle_end_out == periph_tick_out) else $error("machine cycle mismatch");
  periph_half_a: assert property (
    cpu_tick_out || periph_tick_out |-> cpu_tick_out && periph_tick_out == ph_r) else $error("periph rate");
  core_cause_a: assert property (cpu_tick_out |-> $past(osc_tick_out)) else $error("core tick uncaused");
  core_level_a: assert property ($changed(cpu_clk_out) == cpu_tick_out) else $error("core level off");
  osc_pulse_a: assert property (osc_tick_out |=> !osc_tick_out) else $error("select tick too long");
  doubler_force_a: assert property (s_dbl_held |-> rc_dbl_out) else $error("doubler not forced");
  pin_quiet_a: assert property (s_pin_idle |-> !clock_output_pin_o_out) else $error("pin data while off");
endmodule // mcg_clock_gen_checker
bind mcg_clock_gen mcg_clock_gen_checker u_chk (.clk_in, .srst_in, .user_config_byte_two_in, .xaddr_in, .xrd_in, .sfr_addr_in,
  .sfr_rd_in, .xrdata_out, .sfr_rdata_out, .osc_tick_out, .cpu_tick_out, .periph_tick_out, .mcycle_end_out,
  .cpu_clk_out, .rc_dbl_out, .low_power_out, .clock_output_pin_o_out, .clock_output_pin_oe_n_out);

// [testbench/mcg_core_model.sv]
// Core and peripheral model that counts the clocks it receives
`timescale 1ns/10ps
module mcg_core_model (
  input  wire        clk_in,    // Clock
  input  wire        clr_in,    // Clear counts
  input  wire        osc_in,    // Select tick
  input  wire        cpu_in,    // Core tick
  input  wire        per_in,    // Periph tick
  input  wire        pin_in,    // Output pin level
  output reg  [15:0] osc_n_out, // Select ticks
  output reg  [15:0] cpu_n_out, // Core ticks
  output reg  [15:0] per_n_out, // Periph ticks
  output reg  [15:0] tog_n_out  // Pin toggles
);
  reg pin_r;
  always @(posedge clk_in) begin
    pin_r <= pin_in;
    osc_n_out <= clr_in ? 16'h0000 : osc_n_out + osc_in;
    cpu_n_out <= clr_in ? 16'h0000 : cpu_n_out + cpu_in;
    per_n_out <= clr_in ? 16'h0000 : per_n_out + per_in;
    tog_n_out <= clr_in ? 16'h0000 : tog_n_out + (pin_r ^ pin_in);
  end
endmodule // mcg_core_model

// [testbench/mcg_clock_gen_bench.sv]
// Self-checking bench for the clock generation block
`timescale 1ns/10ps
`include "mcg_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module mcg_clock_gen_bench;
  localparam [15:0] CC = `MCG_CLKCTL_ADDR, TR = {8'h00, `MCG_TRIM_ADDR}, DV = {8'h00, `MCG_DIVIDER_ADDR};
  localparam [15:0] AX = {8'h00, `MCG_AUXCTL_ADDR};
  reg         clk_in = 0, srst_in = 1, xtal = 0, rc = 0, wd = 0, ext = 0, rtc = 0, clr = 1;
  reg         xwr = 0, xrd = 0, swr = 0, srd = 0, wr;
  reg  [7:0]  user_config_byte_one, user_config_byte_two, xwd, sa, swd, q;
  reg  [5:0]  trimv;
  reg  [15:0] xa;
  reg  [2:0]  src;
  reg  [11:0] tbl = {`MCG_SRC_XTAL_HI, `MCG_SRC_WDOSC, `MCG_SRC_EXT, `MCG_SRC_RC};
  wire [7:0]  xrd_d, srd_d;
  wire [5:0]  trim_o;
  wire [15:0] n_osc, n_cpu, n_per, n_tog;
  wire        osc_t, cpu_t, per_t, pin_o, pin_oe_n, dbl, lp, wdr, wdt_x;
  integer     seed = 32'h00e998b6, n_fail = 0, compares = 0, cyc = 0, i, f, d;
  always #2.5 clk_in = ~clk_in;
  always #23 xtal = ~xtal;
  always #17 rc = ~rc;
  always #41 wd = ~wd;
  always #29 ext = ~ext;
  mcg_clock_gen DUT (.clk_in(clk_in), .srst_in(srst_in), .user_config_byte_one_in(user_config_byte_one), .user_config_byte_two_in(user_config_byte_two),
    .trim_factory_in(trimv), .xtal_osc_in(xtal), .rc_osc_in(rc), .wd_osc_in(wd), .ext_clk_in(ext),
    .rtc_xtal_in(rtc), .xaddr_in(xa), .xwdata_in(xwd), .xwr_in(xwr), .xrd_in(xrd), .sfr_addr_in(sa),
    .sfr_wdata_in(swd), .sfr_wr_in(swr), .sfr_rd_in(srd), .xrdata_out(xrd_d), .sfr_rdata_out(srd_d),
    .osc_tick_out(osc_t), .cpu_tick_out(cpu_t), .cpu_clk_out(), .periph_tick_out(per_t), .mcycle_end_out(),
    .rc_dbl_out(dbl), .rc_trim_out(trim_o), .wd_rate_out(wdr), .wdt_xtal_out(wdt_x), .low_power_out(lp),
    .clock_output_pin_o_out(pin_o), .clock_output_pin_oe_n_out(pin_oe_n));
  mcg_core_model u_core (.clk_in(clk_in), .clr_in(clr), .osc_in(osc_t), .cpu_in(cpu_t), .per_in(per_t),
    .pin_in(pin_o), .osc_n_out(n_osc), .cpu_n_out(n_cpu), .per_n_out(n_per), .tog_n_out(n_tog));
  function [7:0] cc_exp(input ok, input rate, input db, input [2:0] s);
    cc_exp = {ok, 1'b0, rate, 1'b0, db, s};
  endfunction
  // Divide factor: twice the divider value, zero means one
  function integer div_factor(input [7:0] dv);
    div_factor = (dv == 8'h00) ? 1 : 2 * dv;
  endfunction
  // One byte access; x picks external data space, else direct space
  task acc(input x, input w, input [15:0] a, input [7:0] dv);
    @(posedge clk_in); #1;
    if (x) begin xa = a; xwd = dv; xwr = w; xrd = !w; end
    else begin sa = a[7:0]; swd = dv; swr = w; srd = !w; end
    @(posedge clk_in); #1;
    q = x ? xrd_d : srd_d;
    {xwr, xrd, swr, srd} = 4'h0;
  endtask
  // Poll the control register until the switch-complete flag is back
  task wait_ok;
    f = 0;
    do begin acc(1, 0, CC, 0); f++; end while (q[7] !== 1'b1 && f < 1000);
  endtask
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    xa = 0; xwd = 0; sa = 0; swd = 0;
    user_config_byte_one = $random(seed); user_config_byte_two = $random(seed); trimv = $random(seed);
    i = $random(seed) & 3; src = tbl[3*i +: 3]; user_config_byte_one[2:0] = src;
    repeat (2) @(posedge clk_in); #1 srst_in = 0;
    acc(1, 0, CC, 0); `CHK(q & 8'hbf, cc_exp(1'b1, 1'b0, user_config_byte_one[7], src))
    acc(0, 0, TR, 0); `CHK(q, {2'b00, trimv})
    acc(0, 0, AX, 0); `CHK(q, 8'h00)
    acc(0, 0, 16'h0090, 0); `CHK(q, 8'h00)
    `CHK(dbl, user_config_byte_one[7] | user_config_byte_two[7])
    $display("reset test done");
    for (i = 3; i >= 0; i--) begin
      wr = $random(seed);
      acc(1, 1, CC, cc_exp(1'b0, wr, user_config_byte_one[7], tbl[3*i +: 3]));
      acc(1, 0, CC, 0);
      // Same code starts no switch, so a second write would be taken
      if (src != tbl[3*i +: 3]) begin
        `CHK(q[7], 1'b0)
        acc(1, 1, CC, cc_exp(1'b0, !wr, user_config_byte_one[7], `MCG_SRC_XTAL_LO));
      end
      wait_ok;
      src = tbl[3*i +: 3];
      `CHK(q & 8'hbf, cc_exp(1'b1, wr, user_config_byte_one[7], src))
      `CHK(wdr, wr)
    end
    acc(1, 1, CC, cc_exp(1'b0, wr, user_config_byte_one[7], `MCG_SRC_RC) | 8'h10);
    wait_ok; `CHK(q[4], 1'b0)
    `CHK(wdt_x, 1'b0)
    acc(1, 1, CC, cc_exp(1'b0, wr, user_config_byte_one[7], `MCG_SRC_XTAL_LO) | 8'h10);
    wait_ok; `CHK(q & 8'hbf, cc_exp(1'b1, wr, user_config_byte_one[7], `MCG_SRC_XTAL_LO) | 8'h10)
    `CHK(wdt_x, 1'b1)
    acc(1, 1, CC, cc_exp(1'b0, wr, user_config_byte_one[7], `MCG_SRC_RC));
    wait_ok; `CHK(wdt_x, 1'b0)
    $display("switch test done");
    trimv = $random(seed);
    acc(0, 1, TR, {2'b01, trimv});
    repeat (4) @(posedge clk_in);
    `CHK(pin_oe_n, 1'b0)
    `CHK(trim_o, trimv)
    for (i = 0; i < 3; i++) begin
      d = i + (i == 2);
      f = div_factor(d);
      acc(0, 1, DV, d);
      repeat (50) @(posedge clk_in); #1 clr = 0;
      repeat (600) @(posedge clk_in); #1 clr = 1;
      d = n_osc - n_cpu * f; `CHK(d >= -f && d <= f, 1'b1)
      d = n_cpu - 2 * n_per; `CHK(d >= -1 && d <= 1, 1'b1)
      d = n_tog - n_cpu; `CHK(d >= -1 && d <= 1, 1'b1)
    end
    acc(0, 1, AX, 8'h80);
    acc(0, 0, AX, 0); `CHK(q, 8'h80)
    `CHK(lp, 1'b1)
    rtc = 1;
    user_config_byte_two[7] = 1'b1;
    repeat (4) @(posedge clk_in);
    `CHK(pin_oe_n, 1'b1)
    `CHK(dbl, 1'b1)
    $display("clock test done");
    print_verdict;
  end
endmodule // mcg_clock_gen_bench
